// ### design/pmlh_pkg.sv
package pmlh_pkg;

	localparam int          NUM_CH      = 4;
	localparam int          CLK_HZ      = 40000000;
	// Highest serial clock the host may use in on mode
	localparam int          SCLK_MAX_HZ = 5000000;

	// Channel mode encoding
	localparam logic [1:0]  CH_OFF_NODIAG = 2'h0;
	localparam logic [1:0]  CH_FOLLOW_IN  = 2'h1;
	localparam logic [1:0]  CH_ON_DIAG    = 2'h2;
	localparam logic [1:0]  CH_OFF_DIAG   = 2'h3;

	localparam logic [7:0]  CH_MODE_RST   = 8'h00;
	localparam logic [3:0]  OUT_RST       = 4'h0;

	typedef enum logic [1:0]
	{
		PM_SLEEP = 2'h0,
		PM_IDLE  = 2'h1,
		PM_ON    = 2'h2,
		PM_LIMP  = 2'h3
	} pmlh_mode_t;

	typedef struct packed
	{
		logic        valid;
		logic [7:0]  modes;
	} pmlh_cfg_t;

	typedef struct packed
	{
		logic [1:0]  rst_n_sync;
		logic [1:0]  limp_sync;
		logic [7:0]  in_sync;
		logic        sclk_sync0;
		logic        sclk_sync1;
		logic        sclk_prev;
	} pmlh_sync_t;

	typedef struct packed
	{
		pmlh_mode_t  mode;
		pmlh_sync_t  sync;
		logic [7:0]  ch_mode;
		logic [3:0]  channel_output;
		logic [3:0]  diag_en;
		logic        transmission_error_flag;
		logic        err_pending;
		logic        regs_reset;
	} pmlh_state_t;

endpackage

// ### design/pmlh_ctrl.sv
`timescale 1ns/1ps
// Function
// - Power-on reset clears registers and leaves the device idle.
// - Reset pin low clears registers and enters sleep.
// - Sleep when reset pin low and limp request low.
// - Idle keeps all channels off and diagnosis inactive.
// - On mode drives enabled channels with diagnosis; host limits serial clock.
// - Limp request high enters limp home, clears registers, routes pins.
// - In limp home, input n drives output n.
// - Serial commands are ignored during limp home.
// - Limp request overrides reset pin and wakes from sleep.
// - Each transfer during limp home returns the error flag.
// - Leaving limp home clears registers, then sleep or on mode.
// - First transfer after limp home also returns the error flag.
// - Four channel modes: off, follow input, on diag, off diag.
// - All channels off without diagnosis puts device idle.
// - Open input reads low, so a following channel is off.
// - Following channel is on for high input, off for low.
module pmlh_ctrl
(
	// Clock and power-on reset
	input  wire logic               clk,
	input  wire logic               rst,
	// Control pins from the host
	input  wire logic               reset_pin_n,
	input  wire logic               limp_home_request,
	input  wire logic [3:0]         channel_control_input,
	input  wire logic               sclk,
	// Channel modes from the serial logic
	input  wire pmlh_pkg::pmlh_cfg_t cfg,
	// Transfer framing from the serial logic
	input  wire logic               xfer_done,
	// Channel drive and status
	output logic      [3:0]         channel_output,
	output logic      [3:0]         diag_en,
	output logic      [7:0]         ch_mode_q,
	output pmlh_pkg::pmlh_mode_t    power_mode,
	output logic                    transmission_error_flag,
	output logic                    regs_reset
);

	pmlh_pkg::pmlh_state_t  state_ff;
	pmlh_pkg::pmlh_state_t  nxt_state;

	// One channel's drive level for a given mode and pin level
	function automatic logic ch_drive(input logic [1:0] m, input logic pin);
		logic r;
		r = 1'b0;
		case (m)
			pmlh_pkg::CH_FOLLOW_IN: r = pin;
			pmlh_pkg::CH_ON_DIAG:   r = 1'b1;
			default:                r = 1'b0;
		endcase
		return r;
	endfunction

	always_comb
	begin
		logic        rstn_s;
		logic        limp_s;
		logic [3:0]  pins_s;
		logic        sclk_edge;
		logic        all_off;
		rstn_s    = state_ff.sync.rst_n_sync[1];
		limp_s    = state_ff.sync.limp_sync[1];
		pins_s    = {state_ff.sync.in_sync[7], state_ff.sync.in_sync[5],
			state_ff.sync.in_sync[3], state_ff.sync.in_sync[1]};
		sclk_edge = state_ff.sync.sclk_sync1 & ~state_ff.sync.sclk_prev;
		all_off   = 1'b1;
		nxt_state = state_ff;

		// Two-stage synchronisers; stage 0 feeds only stage 1
		nxt_state.sync.rst_n_sync = {state_ff.sync.rst_n_sync[0], reset_pin_n};
		nxt_state.sync.limp_sync  = {state_ff.sync.limp_sync[0],
			limp_home_request};
		for (int i = 0; i < pmlh_pkg::NUM_CH; i++)
		begin
			nxt_state.sync.in_sync[2*i+1] = state_ff.sync.in_sync[2*i];
			nxt_state.sync.in_sync[2*i]   = channel_control_input[i];
		end
		nxt_state.sync.sclk_sync0 = sclk;
		nxt_state.sync.sclk_sync1 = state_ff.sync.sclk_sync0;
		nxt_state.sync.sclk_prev  = state_ff.sync.sclk_sync1;
		nxt_state.regs_reset      = 1'b0;

		// Mode stores follow serial writes only outside limp home and sleep
		if (cfg.valid && state_ff.mode != pmlh_pkg::PM_LIMP
			&& state_ff.mode != pmlh_pkg::PM_SLEEP)
			nxt_state.ch_mode = cfg.modes;
		for (int i = 0; i < pmlh_pkg::NUM_CH; i++)
			if (nxt_state.ch_mode[2*i+:2] != pmlh_pkg::CH_OFF_NODIAG)
				all_off = 1'b0;

		case (state_ff.mode)
			pmlh_pkg::PM_LIMP:
			begin
				if (!limp_s)
				begin
					nxt_state.ch_mode     = pmlh_pkg::CH_MODE_RST;
					nxt_state.regs_reset  = 1'b1;
					nxt_state.err_pending = 1'b1;
					nxt_state.mode = rstn_s ? pmlh_pkg::PM_ON
						: pmlh_pkg::PM_SLEEP;
				end
				else
					nxt_state.ch_mode = pmlh_pkg::CH_MODE_RST;
			end
			default:
			begin
				if (limp_s)
				begin
					// Wins over a low reset pin, waking from sleep
					nxt_state.mode       = pmlh_pkg::PM_LIMP;
					nxt_state.ch_mode    = pmlh_pkg::CH_MODE_RST;
					nxt_state.regs_reset = 1'b1;
				end
				else if (!rstn_s)
				begin
					nxt_state.mode    = pmlh_pkg::PM_SLEEP;
					nxt_state.ch_mode = pmlh_pkg::CH_MODE_RST;
					nxt_state.regs_reset = 1'b1;
				end
				else if (state_ff.mode == pmlh_pkg::PM_SLEEP)
					nxt_state.mode = pmlh_pkg::PM_IDLE;
				else if (all_off)
					nxt_state.mode = pmlh_pkg::PM_IDLE;
				else
					nxt_state.mode = pmlh_pkg::PM_ON;
			end
		endcase

		// Channel drive per resulting mode
		for (int i = 0; i < pmlh_pkg::NUM_CH; i++)
		begin
			case (nxt_state.mode)
				pmlh_pkg::PM_LIMP:
				begin
					nxt_state.channel_output[i] = pins_s[i];
					nxt_state.diag_en[i]        = 1'b0;
				end
				pmlh_pkg::PM_ON:
				begin
					nxt_state.channel_output[i] =
						ch_drive(nxt_state.ch_mode[2*i+:2], pins_s[i]);
					nxt_state.diag_en[i] =
						nxt_state.ch_mode[2*i+:2] != pmlh_pkg::CH_OFF_NODIAG;
				end
				default:
				begin
					nxt_state.channel_output[i] = 1'b0;
					nxt_state.diag_en[i]        = 1'b0;
				end
			endcase
		end
		// Just out of limp home into on mode all channels idle but diagnosis enabled on all four
		if (state_ff.mode == pmlh_pkg::PM_LIMP
			&& nxt_state.mode == pmlh_pkg::PM_ON)
			nxt_state.diag_en = 4'hF;

		// Error flag reported with each finished transfer
		if (xfer_done)
		begin
			if (state_ff.mode == pmlh_pkg::PM_LIMP)
				nxt_state.transmission_error_flag = 1'b1;
			else if (state_ff.err_pending)
			begin
				nxt_state.transmission_error_flag = 1'b1;
				nxt_state.err_pending = 1'b0;
			end
			else
				nxt_state.transmission_error_flag = 1'b0;
		end
		// A serial clock edge seen during sleep pulses the register reset
		if (sclk_edge && state_ff.mode == pmlh_pkg::PM_SLEEP)
			nxt_state.regs_reset = 1'b1;
		// A new limp entry re-arms the post-limp report
		if (nxt_state.mode == pmlh_pkg::PM_LIMP)
			nxt_state.err_pending = 1'b1;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			state_ff <= '0;
			// Reset pin synchroniser starts at its released level, so a
			// power-on reset never passes through a false sleep
			state_ff.sync.rst_n_sync <= 2'h3;
			state_ff.mode <= pmlh_pkg::PM_IDLE;
			state_ff.ch_mode <= pmlh_pkg::CH_MODE_RST;
			state_ff.regs_reset <= 1'b1;
		end
		else
			state_ff <= nxt_state;
	end

	assign channel_output          = state_ff.channel_output;
	assign diag_en                 = state_ff.diag_en;
	assign ch_mode_q               = state_ff.ch_mode;
	assign power_mode              = state_ff.mode;
	assign transmission_error_flag = state_ff.transmission_error_flag;
	assign regs_reset              = state_ff.regs_reset;

endmodule

// ### verification/pmlh_ctrl_checker.sv
`timescale 1ns/1ps
module pmlh_ctrl_checker
(
	// Clock, reset and inputs
	input wire logic clk, rst, reset_pin_n, limp_home_request, xfer_done,
	input wire logic [3:0] channel_control_input,
	input wire pmlh_pkg::pmlh_cfg_t cfg,
	// Outputs watched
	input wire logic [3:0] channel_output, diag_en,
	input wire logic [7:0] ch_mode_q,
	input wire pmlh_pkg::pmlh_mode_t power_mode,
	input wire logic transmission_error_flag, regs_reset
);
	wire in_limp = power_mode == pmlh_pkg::PM_LIMP;
	wire in_on = power_mode == pmlh_pkg::PM_ON;
	wire in_idle = power_mode == pmlh_pkg::PM_IDLE;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	AST_ROUTE: assert property (in_limp[*4] |-> channel_output ==
		$past(channel_control_input, 3)) else $error("limp routing");
	AST_ENTRY: assert property ($rose(in_limp) |-> regs_reset &&
		ch_mode_q == 8'h00) else $error("limp entry");
	AST_FLAG: assert property (xfer_done && in_limp |=>
		transmission_error_flag) else $error("limp flag");
	AST_IDLE: assert property (in_idle |-> channel_output == 4'h0 &&
		diag_en == 4'h0) else $error("idle drive");
	AST_LOAD: assert property (cfg.valid && (in_on || in_idle) |=>
		ch_mode_q == $past(cfg.modes)) else $error("mode load");
	AST_ALLOFF: assert property (in_on && ch_mode_q == 8'h00 |=>
		!in_on) else $error("all off");
	AST_SLEEP: assert property ((!reset_pin_n && !limp_home_request)[*4]
		|-> power_mode == pmlh_pkg::PM_SLEEP) else $error("sleep");
	AST_WINS: assert property (limp_home_request[*4] |-> in_limp)
		else $error("limp priority");
endmodule
bind pmlh_ctrl pmlh_ctrl_checker pmlh_ctrl_checker_i (.clk, .rst,
	.reset_pin_n, .limp_home_request, .xfer_done, .channel_control_input,
	.cfg, .channel_output, .diag_en, .ch_mode_q, .power_mode,
	.transmission_error_flag, .regs_reset);

// ### verification/pmlh_host.sv
`timescale 1ns/1ps
module pmlh_host
(
	// Frame request from the bench
	input wire logic frame,
	// Serial clock pin
	output logic     sclk
);
	// Parks low between frames so sleep sees a still clock
	initial sclk = 1'b0;
	always #100 sclk = frame ? ~sclk : 1'b0;
endmodule

// ### verification/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	logic clk, rst, reset_pin_n, limp_home_request, sclk, frame, xfer_done;
	logic transmission_error_flag, regs_reset;
	logic [3:0] channel_control_input, channel_output, diag_en;
	logic [7:0] ch_mode_q;
	pmlh_pkg::pmlh_cfg_t cfg;
	pmlh_pkg::pmlh_mode_t power_mode;
	int errors = 0, check_count = 0;
	pmlh_host pmlh_host_i (.frame, .sclk);
	pmlh_ctrl pmlh_ctrl_i (.clk, .rst, .reset_pin_n, .limp_home_request,
		.channel_control_input, .sclk, .cfg, .xfer_done, .channel_output,
		.diag_en, .ch_mode_q, .power_mode, .transmission_error_flag,
		.regs_reset);
	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic chk(input logic [15:0] seen, exp);
		check_count++;
		if (seen !== exp)
		begin
			errors++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Extra cycle lets the registered answer settle before a compare
	task automatic set_modes(input logic [7:0] m);
		cfg = '{valid: 1'b1, modes: m};
		tick(1);
		cfg.valid = 1'b0;
		tick(1);
	endtask
	task automatic xfer(input logic flag);
		frame = 1'b1;
		tick(40);
		{frame, xfer_done} = 2'b01;
		tick(1);
		xfer_done = 1'b0;
		chk(transmission_error_flag, flag);
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial
	begin
		#40000;
		errors++;
		tally_and_finish();
	end
	initial
	begin
		rst = 1'b1;
		reset_pin_n = 1'b1;
		{limp_home_request, frame, xfer_done, cfg} = '0;
		channel_control_input = 4'hF;
		tick(3);
		rst = 1'b0;
		tick(1);
		chk(power_mode, pmlh_pkg::PM_IDLE);
		tick(3);
		chk({power_mode, ch_mode_q}, {pmlh_pkg::PM_IDLE, 8'h00});
		set_modes({pmlh_pkg::CH_OFF_DIAG, pmlh_pkg::CH_ON_DIAG,
			pmlh_pkg::CH_FOLLOW_IN, pmlh_pkg::CH_OFF_NODIAG});
		chk({power_mode, channel_output, diag_en[3:2]},
			{pmlh_pkg::PM_ON, 4'h6, 2'h3});
		channel_control_input = 4'h0;
		tick(3);
		chk(channel_output, 4'h4);
		set_modes(8'h00);
		chk(power_mode, pmlh_pkg::PM_IDLE);
		set_modes(8'h02);
		limp_home_request = 1'b1;
		channel_control_input = 4'hA;
		tick(4);
		chk({power_mode, channel_output, ch_mode_q},
			{pmlh_pkg::PM_LIMP, 4'hA, 8'h00});
		set_modes(8'hAA);
		chk({channel_output, ch_mode_q}, {4'hA, 8'h00});
		xfer(1'b1);
		limp_home_request = 1'b0;
		tick(3);
		chk({power_mode, diag_en, channel_output},
			{pmlh_pkg::PM_ON, 4'hF, 4'h0});
		xfer(1'b1);
		xfer(1'b0);
		reset_pin_n = 1'b0;
		tick(4);
		chk({power_mode, regs_reset}, {pmlh_pkg::PM_SLEEP, 1'b1});
		limp_home_request = 1'b1;
		tick(4);
		chk(power_mode, pmlh_pkg::PM_LIMP);
		limp_home_request = 1'b0;
		tick(4);
		chk(power_mode, pmlh_pkg::PM_SLEEP);
		tally_and_finish();
	end
endmodule
